// *** logic/cdec_pkg.sv ***
package cdec_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_LOW_FLAGS = 12'h788;
  localparam logic [11:0] IDX_UART_DISC = 12'h789;
  localparam logic [11:0] IDX_HIGH_DISC = 12'h78A;
  localparam logic [11:0] IDX_UART_VHI = 12'h78C;
  localparam logic [11:0] IDX_UART_VLO = 12'h78D;
  localparam logic [11:0] IDX_HIGH_VHI = 12'h78E;
  localparam logic [11:0] IDX_HIGH_VLO = 12'h78F;
  localparam logic [11:0] IDX_CTRL = 12'h7F0;
  localparam logic [11:0] IDX_IRQ_STAT = 12'h7F1;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h7F2;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLG_CRC = 0;
  localparam int FLG_UNEXP = 1;
  localparam int FLG_BYTE = 2;
  localparam int FLG_SOF = 3;
  localparam int FLG_FWD_BLOCKED = 4;
  localparam int FLG_ABANDON = 5;
  localparam int FLG_W = 6;
  localparam int IRQ_UART_DISC = 6;
  localparam int IRQ_HIGH_DISC = 7;
  localparam int CTRL_DIR_SEL = 0;
  // ----------------------------------------------------------------
  // reset values, limits, responses
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] DISC_MAX = 8'hFF;
  localparam logic [15:0] VALID_MAX = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : cdec_pkg

// *** logic/cdec_frame_tally.sv ***
`timescale 1ns/100ps
module cdec_frame_tally (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic discard_in,
  input wire logic valid_in,
  input wire logic snap_in,
  output logic [7:0] disc_live_out,
  output logic [7:0] disc_snap_out,
  output logic [15:0] valid_snap_out
);
  import cdec_pkg::*;

  typedef struct packed {
    logic [7:0] disc_live;
    logic [15:0] valid_live;
    logic [7:0] disc_snap;
    logic [15:0] valid_snap;
  } cdec_tally_t;

  cdec_tally_t st;
  cdec_tally_t next_st;

  always_comb begin
    next_st = st;
    if (ce_in) begin
      if (snap_in) begin
        next_st.disc_snap = st.disc_live; // RULE10
        next_st.valid_snap = st.valid_live; // RULE13
        next_st.disc_live = {7'h00, discard_in};
        next_st.valid_live = {15'h0000, valid_in};
      end else begin
        if (discard_in && st.disc_live != DISC_MAX) begin
          next_st.disc_live = st.disc_live + 8'h01; // RULE14
        end
        if (valid_in && st.valid_live != VALID_MAX) begin
          next_st.valid_live = st.valid_live + 16'h0001; // RULE13
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st <= '{RST_BYTE, RST_WORD, RST_BYTE, RST_WORD};
    end else begin
      st <= next_st;
    end
  end

  assign disc_live_out = st.disc_live;
  assign disc_snap_out = st.disc_snap;
  assign valid_snap_out = st.valid_snap;

  AST_DISC_SAT: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE14
    ce_in && !snap_in && discard_in && st.disc_live == DISC_MAX |=> st.disc_live == DISC_MAX)
    else $error("discard counter wrapped");
  AST_VALID_SAT: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE13
    ce_in && !snap_in && st.valid_live == VALID_MAX |=> st.valid_live == VALID_MAX)
    else $error("valid counter left saturation");
  AST_SNAP: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE12
    ce_in && snap_in |=> st.disc_snap == $past(st.disc_live)
      && st.valid_snap == $past(st.valid_live) && st.disc_live <= 8'h01)
    else $error("snapshot or clear on read wrong");
  COV_SAT: cover property (@(posedge clk_in) st.disc_live == DISC_MAX && discard_in);
endmodule : cdec_frame_tally

// *** logic/cdec_resp_checker.sv ***
`timescale 1ns/100ps
module cdec_resp_checker (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic dir_sel_in,
  input wire logic done_in,
  input wire logic sof_err_in,
  input wire logic byte_err_in,
  input wire logic crc_byte_err_in,
  input wire logic crc_fail_in,
  input wire logic tx_disabled_in,
  input wire logic abandon_in,
  output logic [cdec_pkg::FLG_W-1:0] set_out,
  output logic blocked_out
);
  import cdec_pkg::*;

  typedef struct packed {
    logic [FLG_W-1:0] set;
    logic blocked;
  } cdec_chk_t;

  cdec_chk_t st;
  cdec_chk_t next_st;

  always_comb begin
    next_st = st;
    if (ce_in) begin
      next_st.set = '0;
      next_st.blocked = 1'b0;
      next_st.set[FLG_ABANDON] = abandon_in;
      if (done_in) begin
        if (crc_fail_in || crc_byte_err_in) begin
          // discarded on checksum: other faults hidden except abandon and a byte fault on the checksum byte
          next_st.set[FLG_CRC] = 1'b1; // RULE6 RULE7
          next_st.set[FLG_BYTE] = crc_byte_err_in; // RULE8
        end else if (!dir_sel_in) begin
          next_st.set[FLG_UNEXP] = 1'b1; // RULE5
        end else begin
          next_st.set[FLG_FWD_BLOCKED] = tx_disabled_in; // RULE1
          next_st.blocked = tx_disabled_in; // RULE2
          next_st.set[FLG_SOF] = sof_err_in; // RULE3
          next_st.set[FLG_BYTE] = byte_err_in; // RULE4
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign set_out = st.set;
  assign blocked_out = st.blocked;

  sequence good_frame_s;
    ce_in && done_in && !crc_fail_in && !crc_byte_err_in;
  endsequence
  AST_FWD_BLOCKED: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE1
    good_frame_s ##0 dir_sel_in && tx_disabled_in |=> st.set[FLG_FWD_BLOCKED] && st.blocked)
    else $error("forward block not flagged");
  AST_BLOCK_DISC: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE2
    st.blocked |-> st.set[FLG_FWD_BLOCKED])
    else $error("discard without blocked flag");
  AST_SOF: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE3
    good_frame_s ##0 dir_sel_in |=> st.set[FLG_SOF] == $past(sof_err_in))
    else $error("start error flag mismatch");
  AST_BYTE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE4
    good_frame_s ##0 dir_sel_in |=> st.set[FLG_BYTE] == $past(byte_err_in))
    else $error("byte fault flag mismatch");
  AST_UNEXP: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE5
    good_frame_s ##0 !dir_sel_in |=> st.set[FLG_UNEXP] && !st.set[FLG_SOF])
    else $error("unexpected response not flagged");
  AST_CRC: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE6
    ce_in && done_in && crc_fail_in |=> st.set[FLG_CRC] && !st.set[FLG_UNEXP])
    else $error("checksum fault not flagged");
  AST_SUPPRESS: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE7
    ce_in && done_in && crc_fail_in && !crc_byte_err_in && !abandon_in
      |=> st.set == 6'h01 && !st.blocked)
    else $error("faults not suppressed on checksum discard");
  AST_CRC_BYTE: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE8
    ce_in && done_in && crc_byte_err_in |=> st.set[FLG_CRC] && st.set[FLG_BYTE])
    else $error("final byte fault lacks both flags");
  COV_CRC: cover property (@(posedge clk_in) ce_in && done_in && crc_fail_in);
endmodule : cdec_resp_checker

// *** logic/cdec_top.sv ***
// Operation
// [RULE1] With direction select 1, a response that cannot be forwarded because the transmitter is off sets the forward-blocked flag.
// [RULE2] Such a blocked response counts as a discarded frame of the low-side port.
// [RULE3] With direction select 1, a frame with the start bit that is not the expected initialisation frame sets the start error flag.
// [RULE4] With direction select 1, a byte error in a response, other than in the initialisation byte, sets the byte fault flag.
// [RULE5] With direction select 0, a response arriving on the low-side port sets the unexpected-response flag.
// [RULE6] A checksum mismatch that discards a low-side response sets the checksum fault flag.
// [RULE7] A checksum-discarded response reports the checksum fault and hides most other faults.
// [RULE8] A byte error on the final checksum byte sets both the checksum and byte fault flags.
// [RULE9] An 8-bit read-only counter of discarded host serial frames resets to zero.
// [RULE10] Reading the host serial discard count snapshots its discard and valid counts and clears the live ones.
// [RULE11] An 8-bit read-only counter of discarded high-side frames resets to zero.
// [RULE12] Reading the high-side discard count snapshots its discard and valid counts and clears the live ones.
// [RULE13] Each valid-frame count is 16 bits in two bytes and saturates at all ones.
// [RULE14] Discard counts saturate at their maximum instead of wrapping.
`timescale 1ns/100ps
module cdec_top (
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  input wire logic CE_IN,
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  input wire logic AXI_AWVALID_IN,
  input wire logic [cdec_pkg::ADDR_W-1:0] AXI_AWADDR_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic AXI_WVALID_IN,
  input wire logic [cdec_pkg::DATA_W-1:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  output logic AXI_WREADY_OUT,
  output logic AXI_BVALID_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic AXI_ARVALID_IN,
  input wire logic [cdec_pkg::ADDR_W-1:0] AXI_ARADDR_IN,
  output logic AXI_ARREADY_OUT,
  output logic AXI_RVALID_OUT,
  output logic [cdec_pkg::DATA_W-1:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  input wire logic AXI_RREADY_IN,
  // ----------------------------------------------------------------
  // frame events from the link logic, and status outputs
  // ----------------------------------------------------------------
  input wire logic LOW_RESP_DONE_IN,
  input wire logic LOW_RESP_SOF_ERR_IN,
  input wire logic LOW_RESP_BYTE_ERR_IN,
  input wire logic LOW_RESP_CRC_BYTE_ERR_IN,
  input wire logic LOW_RESP_CRC_FAIL_IN,
  input wire logic TX_DISABLED_IN,
  input wire logic RESP_ABANDON_IN,
  input wire logic UART_DISCARD_IN,
  input wire logic UART_VALID_IN,
  input wire logic HIGH_DISCARD_IN,
  input wire logic HIGH_VALID_IN,
  output logic DIR_SEL_OUT,
  output logic LOW_DISCARD_OUT,
  output logic IRQ_OUT
);
  import cdec_pkg::*;

  default clocking cb_sys @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_B_IN);

  typedef struct packed {
    logic aw_rdy;
    logic aw_seen;
    logic [ADDR_W-1:0] aw_addr;
    logic w_rdy;
    logic w_seen;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic dir_sel;
    logic [7:0] flags;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic irq;
    logic low_discard;
  } cdec_top_state_t;

  cdec_top_state_t st;
  cdec_top_state_t next_st;

  logic [FLG_W-1:0] chk_set;
  logic chk_blocked;
  logic [7:0] uart_live;
  logic [7:0] uart_snap;
  logic [15:0] uart_valid;
  logic [7:0] high_live;
  logic [7:0] high_snap;
  logic [15:0] high_valid;
  logic ar_hs;
  logic [11:0] ar_idx;
  logic ar_ok;
  logic snap_uart;
  logic snap_high;

  // ----------------------------------------------------------------
  // low-side response checking and port counters
  // ----------------------------------------------------------------
  cdec_resp_checker u_checker (
    .clk_in(CLK_SYS_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .dir_sel_in(st.dir_sel),
    .done_in(LOW_RESP_DONE_IN),
    .sof_err_in(LOW_RESP_SOF_ERR_IN),
    .byte_err_in(LOW_RESP_BYTE_ERR_IN),
    .crc_byte_err_in(LOW_RESP_CRC_BYTE_ERR_IN),
    .crc_fail_in(LOW_RESP_CRC_FAIL_IN),
    .tx_disabled_in(TX_DISABLED_IN),
    .abandon_in(RESP_ABANDON_IN),
    .set_out(chk_set),
    .blocked_out(chk_blocked)
  );

  cdec_frame_tally u_uart_tally (
    .clk_in(CLK_SYS_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .discard_in(UART_DISCARD_IN),
    .valid_in(UART_VALID_IN),
    .snap_in(snap_uart),
    .disc_live_out(uart_live),
    .disc_snap_out(uart_snap),
    .valid_snap_out(uart_valid)
  );

  cdec_frame_tally u_high_tally (
    .clk_in(CLK_SYS_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .discard_in(HIGH_DISCARD_IN),
    .valid_in(HIGH_VALID_IN),
    .snap_in(snap_high),
    .disc_live_out(high_live),
    .disc_snap_out(high_snap),
    .valid_snap_out(high_valid)
  );

  // ----------------------------------------------------------------
  // read address decode
  // ----------------------------------------------------------------
  assign ar_hs = CE_IN && st.ar_rdy && AXI_ARVALID_IN;
  assign ar_idx = AXI_ARADDR_IN[13:2];
  assign ar_ok = AXI_ARADDR_IN[ADDR_W-1:14] == 2'h0 && AXI_ARADDR_IN[1:0] == 2'h0;
  assign snap_uart = ar_hs && ar_ok && ar_idx == IDX_UART_DISC; // RULE10
  assign snap_high = ar_hs && ar_ok && ar_idx == IDX_HIGH_DISC; // RULE12

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] flag_clr;
    logic [7:0] stat_clr;
    logic [11:0] w_idx;
    logic w_ok;
    flag_clr = 8'h00;
    stat_clr = 8'h00;
    w_idx = st.aw_addr[13:2];
    w_ok = st.aw_addr[ADDR_W-1:14] == 2'h0 && st.aw_addr[1:0] == 2'h0;
    next_st = st;
    if (CE_IN) begin
      // write channel capture, either order
      if (st.aw_rdy && AXI_AWVALID_IN) begin
        next_st.aw_seen = 1'b1;
        next_st.aw_addr = AXI_AWADDR_IN;
      end
      if (st.w_rdy && AXI_WVALID_IN) begin
        next_st.w_seen = 1'b1;
        next_st.w_data = AXI_WDATA_IN[7:0];
        next_st.w_lane0 = AXI_WSTRB_IN[0];
      end
      if (st.bvalid && AXI_BREADY_IN) begin
        next_st.bvalid = 1'b0;
      end
      if (st.aw_seen && st.w_seen && !st.bvalid) begin
        next_st.aw_seen = 1'b0;
        next_st.w_seen = 1'b0;
        next_st.bvalid = 1'b1;
        next_st.bresp = RESP_OKAY;
        if (!w_ok) begin
          next_st.bresp = RESP_DECERR;
        end else begin
          case (w_idx)
            IDX_CTRL: begin
              if (st.w_lane0) begin
                next_st.dir_sel = st.w_data[CTRL_DIR_SEL];
              end
            end
            IDX_IRQ_MASK: begin
              if (st.w_lane0) begin
                next_st.irq_mask = st.w_data;
              end
            end
            IDX_LOW_FLAGS, IDX_UART_DISC, IDX_HIGH_DISC, IDX_UART_VHI, IDX_UART_VLO,
            IDX_HIGH_VHI, IDX_HIGH_VLO, IDX_IRQ_STAT: begin
              next_st.bresp = RESP_OKAY;
            end
            default: begin
              next_st.bresp = RESP_DECERR;
            end
          endcase
        end
      end
      // read channel
      if (st.rvalid && AXI_RREADY_IN) begin
        next_st.rvalid = 1'b0;
      end
      if (ar_hs) begin
        next_st.rvalid = 1'b1;
        next_st.rresp = RESP_OKAY;
        next_st.rdata = 8'h00;
        if (!ar_ok) begin
          next_st.rresp = RESP_DECERR;
        end else begin
          case (ar_idx)
            IDX_LOW_FLAGS: begin
              next_st.rdata = st.flags;
              flag_clr = 8'hFF;
            end
            IDX_UART_DISC: next_st.rdata = uart_live; // RULE9
            IDX_HIGH_DISC: next_st.rdata = high_live; // RULE11
            IDX_UART_VHI: next_st.rdata = uart_valid[15:8]; // RULE13
            IDX_UART_VLO: next_st.rdata = uart_valid[7:0];
            IDX_HIGH_VHI: next_st.rdata = high_valid[15:8];
            IDX_HIGH_VLO: next_st.rdata = high_valid[7:0];
            IDX_CTRL: next_st.rdata = {7'h00, st.dir_sel};
            IDX_IRQ_STAT: begin
              next_st.rdata = st.irq_stat;
              stat_clr = 8'hFF;
            end
            IDX_IRQ_MASK: next_st.rdata = st.irq_mask;
            default: next_st.rresp = RESP_DECERR;
          endcase
        end
      end
      // sticky flags: a set in the clearing cycle survives
      next_st.flags = (st.flags & ~flag_clr) | {2'b00, chk_set}; // RULE1 RULE6
      next_st.irq_stat = (st.irq_stat & ~stat_clr)
        | {HIGH_DISCARD_IN, UART_DISCARD_IN, chk_set};
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
      next_st.low_discard = chk_blocked; // RULE2
      next_st.aw_rdy = !next_st.aw_seen && !next_st.bvalid;
      next_st.w_rdy = !next_st.w_seen && !next_st.bvalid;
      next_st.ar_rdy = !next_st.rvalid;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign AXI_AWREADY_OUT = st.aw_rdy;
  assign AXI_WREADY_OUT = st.w_rdy;
  assign AXI_BVALID_OUT = st.bvalid;
  assign AXI_BRESP_OUT = st.bresp;
  assign AXI_ARREADY_OUT = st.ar_rdy;
  assign AXI_RVALID_OUT = st.rvalid;
  assign AXI_RDATA_OUT = {24'h000000, st.rdata};
  assign AXI_RRESP_OUT = st.rresp;
  assign DIR_SEL_OUT = st.dir_sel;
  assign LOW_DISCARD_OUT = st.low_discard;
  assign IRQ_OUT = st.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_UART_READ: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // RULE9
    snap_uart |=> AXI_RVALID_OUT && AXI_RDATA_OUT == {24'h000000, $past(uart_live)})
    else $error("host serial discard read wrong");
  AST_HIGH_READ: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // RULE11
    snap_high |=> AXI_RVALID_OUT && AXI_RDATA_OUT == {24'h000000, $past(high_live)})
    else $error("high side discard read wrong");
  AST_UART_SNAP: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // RULE10
    snap_uart |=> uart_snap == $past(uart_live) && uart_live <= 8'h01)
    else $error("host serial snapshot missing");
  AST_FLAG_HOLD: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN) // RULE6
    CE_IN && chk_set[FLG_CRC] |=> st.flags[FLG_CRC])
    else $error("checksum flag lost");
  AST_IRQ: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    IRQ_OUT == |(st.irq_stat & st.irq_mask))
    else $error("interrupt level mismatch");
  AST_RESERVED: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
    st.flags[7:6] == 2'b00)
    else $error("reserved flag bits set");
  AST_BVALID_HOLD: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN
    |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
    else $error("write response dropped early");
  AST_RVALID_HOLD: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN
    |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT))
    else $error("read data dropped early");
  AST_AR_BLOCK: assert property (AXI_RVALID_OUT |-> !AXI_ARREADY_OUT)
    else $error("read address taken while busy");
  AST_W_BLOCK: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT && !AXI_WREADY_OUT)
    else $error("write taken while busy");
  AST_FREEZE: assert property (!CE_IN |=> $stable(st))
    else $error("state moved with enable low");
  AST_LOW_DISC: assert property (CE_IN && chk_blocked |=> LOW_DISCARD_OUT) // RULE2
    else $error("blocked response not counted");
  AST_HIGH_SNAP: assert property ( // RULE12
    snap_high |=> high_snap == $past(high_live) && high_live <= 8'h01)
    else $error("high side snapshot missing");
  AST_FLAG_SET: assert property ( // RULE3 RULE4 RULE5
    CE_IN |=> (st.flags[FLG_W-1:0] & $past(chk_set)) == $past(chk_set))
    else $error("flag set lost");
  AST_STAT_SET: assert property (
    CE_IN && UART_DISCARD_IN |=> st.irq_stat[IRQ_UART_DISC])
    else $error("discard status lost");
  COV_WRITE: cover property (@(posedge CLK_SYS_IN) AXI_BVALID_OUT && AXI_BREADY_IN);
  COV_SNAP: cover property (@(posedge CLK_SYS_IN) snap_high);
  COV_IRQ: cover property (@(posedge CLK_SYS_IN) IRQ_OUT);
endmodule : cdec_top

// *** verification/cdec_link_model.sv ***
`timescale 1ns/100ps
module cdec_link_model (
  input wire logic clk_in,
  output logic done_out,
  output logic sof_out,
  output logic byte_out,
  output logic crcb_out,
  output logic crcf_out,
  output logic txdis_out,
  output logic abandon_out,
  output logic [1:0] disc_out,
  output logic [1:0] valid_out
);
  initial begin
    {done_out, sof_out, byte_out, crcb_out, crcf_out, txdis_out, abandon_out} = 7'h00;
    disc_out = 2'h0;
    valid_out = 2'h0;
  end
  // ----------------------------------------------------------------
  // one frame end, q = {sof, byte, crc byte, crc fail, tx off, abandon}
  // ----------------------------------------------------------------
  task automatic frame(input logic [5:0] q);
    @(posedge clk_in);
    {sof_out, byte_out, crcb_out, crcf_out, txdis_out, abandon_out} <= q;
    done_out <= ~q[0];
    @(posedge clk_in);
    done_out <= 1'b0;
    // qualifiers other than abandon mean nothing without done, so show their inverse and drop abandon
    {sof_out, byte_out, crcb_out, crcf_out, txdis_out, abandon_out} <= {~q[5:1], 1'b0};
  endtask : frame
  // ----------------------------------------------------------------
  // discard and valid pulses on one port, one per cycle
  // ----------------------------------------------------------------
  task automatic count(input int p, input int nd, input int nv);
    int n;
    n = (nd > nv) ? nd : nv;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      disc_out[p] <= (i < nd);
      valid_out[p] <= (i < nv);
    end
    @(posedge clk_in);
    disc_out <= 2'h0;
    valid_out <= 2'h0;
  endtask : count
endmodule : cdec_link_model

// *** verification/tb_comm_debug_error_counters.sv ***
`timescale 1ns/100ps
module tb_comm_debug_error_counters;
  import cdec_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0, ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awready, wready, bvalid, arready, rvalid, dir_sel, low_disc, irq;
  logic [1:0] bresp, rresp, disc, valid;
  logic done, sof, byt, crcb, crcf, txdis, abandon;
  logic [31:0] d;
  logic [1:0] rsp;
  logic [14:0] r;
  logic [14:0] tbl [7];
  int fails = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  cdec_link_model i_link (.clk_in(clk), .done_out(done), .sof_out(sof), .byte_out(byt),
    .crcb_out(crcb), .crcf_out(crcf), .txdis_out(txdis), .abandon_out(abandon),
    .disc_out(disc), .valid_out(valid));
  cdec_top i_dut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
    .AXI_AWVALID_IN(awvalid), .AXI_AWADDR_IN(awaddr), .AXI_AWREADY_OUT(awready),
    .AXI_WVALID_IN(wvalid), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hF),
    .AXI_WREADY_OUT(wready), .AXI_BVALID_OUT(bvalid), .AXI_BRESP_OUT(bresp),
    .AXI_BREADY_IN(bready), .AXI_ARVALID_IN(arvalid), .AXI_ARADDR_IN(araddr),
    .AXI_ARREADY_OUT(arready), .AXI_RVALID_OUT(rvalid), .AXI_RDATA_OUT(rdata),
    .AXI_RRESP_OUT(rresp), .AXI_RREADY_IN(rready), .LOW_RESP_DONE_IN(done),
    .LOW_RESP_SOF_ERR_IN(sof), .LOW_RESP_BYTE_ERR_IN(byt), .LOW_RESP_CRC_BYTE_ERR_IN(crcb),
    .LOW_RESP_CRC_FAIL_IN(crcf), .TX_DISABLED_IN(txdis), .RESP_ABANDON_IN(abandon),
    .UART_DISCARD_IN(disc[0]), .UART_VALID_IN(valid[0]), .HIGH_DISCARD_IN(disc[1]),
    .HIGH_VALID_IN(valid[1]), .DIR_SEL_OUT(dir_sel), .LOW_DISCARD_OUT(low_disc),
    .IRQ_OUT(irq));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] ba(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ba
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] dat);
    logic ta, tw, tb, fin;
    fin = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= dat;
    bready <= 1'b1;
    while (!fin) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        fin = 1'b1;
        chk({30'h0, bresp}, {30'h0, RESP_OKAY}, "write response");
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [15:0] a, output logic [31:0] dat, output logic [1:0] rs);
    logic ta, tr, fin;
    fin = 1'b0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!fin) begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid & rready;
      dat = rdata;
      rs = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        fin = 1'b1;
      end
    end
  endtask : axi_rd
  task automatic rc(input logic [11:0] idx, input logic [31:0] exp);
    axi_rd(ba(idx), d, rsp);
    chk(d, exp, "register read");
    chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "read response");
  endtask : rc
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #(40 * 90000);
    fails++;
    final_report();
  end
  initial begin
    // {dir, sof, byte, crc byte, crc fail, tx off, abandon, flags}
    tbl[0] = {1'b1, 6'b000010, 8'h10};
    tbl[1] = {1'b1, 6'b100000, 8'h08};
    tbl[2] = {1'b1, 6'b010000, 8'h04};
    tbl[3] = {1'b0, 6'b000000, 8'h02};
    tbl[4] = {1'b1, 6'b100110, 8'h01};
    tbl[5] = {1'b1, 6'b001100, 8'h05};
    tbl[6] = {1'b1, 6'b000001, 8'h20};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rc(IDX_LOW_FLAGS, 32'h0);
    for (int k = 0; k < 6; k++) rc(IDX_UART_DISC + 12'(k + (k > 1)), 32'h0);
    rc(IDX_CTRL, 32'h0);
    rc(IDX_IRQ_MASK, 32'h0);
    axi_rd(16'h0004, d, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_DECERR}, "unmapped read");
    axi_wr(ba(IDX_IRQ_MASK), 32'h0000_00FF);
    for (int i = 0; i < 7; i++) begin
      r = tbl[i];
      axi_wr(ba(IDX_CTRL), {31'h0, r[14]});
      chk({31'h0, dir_sel}, {31'h0, r[14]}, "direction select");
      i_link.frame(r[13:8]);
      @(posedge clk);
      @(negedge clk);
      chk({31'h0, low_disc}, {31'h0, r[14] & r[9] & ~r[10] & ~r[11]}, "low discard");
      chk({31'h0, irq}, 32'h1, "irq raised");
      rc(IDX_LOW_FLAGS, {24'h0, r[7:0]});
      rc(IDX_IRQ_STAT, {24'h0, r[7:0]});
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
    end
    axi_wr(ba(IDX_IRQ_MASK), 32'h0);
    ce <= 1'b0;
    i_link.frame(6'b100000);
    ce <= 1'b1;
    rc(IDX_LOW_FLAGS, 32'h0);
    i_link.frame(6'b100000);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    rc(IDX_LOW_FLAGS, 32'h08);
    for (int p = 0; p < 2; p++) begin
      i_link.count(p, 3, 261);
      rc(IDX_UART_DISC + 12'(p), 32'h3);
      rc(IDX_UART_VHI + 12'(2 * p), 32'h1);
      rc(IDX_UART_VLO + 12'(2 * p), 32'h5);
      rc(IDX_UART_DISC + 12'(p), 32'h0);
      rc(IDX_UART_VLO + 12'(2 * p), 32'h0);
    end
    rc(IDX_IRQ_STAT, 32'hC8);
    axi_wr(ba(IDX_HIGH_DISC), 32'h55);
    rc(IDX_HIGH_DISC, 32'h0);
    i_link.count(1, 260, 65540);
    rc(IDX_HIGH_DISC, 32'hFF);
    rc(IDX_HIGH_VHI, 32'hFF);
    rc(IDX_HIGH_VLO, 32'hFF);
    final_report();
  end
endmodule : tb_comm_debug_error_counters
